// ==== wtc_cfg.svh ====
/*
 Register offsets, field positions, reset values and timing figures of the
 watchdog and token control block. Assumes a 20 MHz system clock.
*/
`ifndef WTC_CFG_SVH
`define WTC_CFG_SVH

// register indices; byte address is four times the index
`define WTC_IDX_IDENT_CMD 4'h0
`define WTC_IDX_GEN_CFG 4'h2
`define WTC_IDX_TIMER 4'h4
`define WTC_IDX_STATUS 4'h5

// command bits of ident_and_command
`define WTC_CMD_TOKEN_LAUNCH 0
`define WTC_CMD_WD_CLEAR 1
`define WTC_CMD_SW_RESET 2

// general_configuration fields
`define WTC_CFG_WD_DISABLE 0
`define WTC_CFG_PRIO_HOLD 1
`define WTC_CFG_TOKEN_DISABLE 2
`define WTC_CFG_WD_SRC_FS 3
`define WTC_CFG_TIMESTAMP 4
`define WTC_CFG_RESET 16'h0000

// status fields
`define WTC_ST_ALARM 0
`define WTC_ST_CLK_FAULT 1
`define WTC_ST_TOKEN_HELD 2

// watchdog: 0.25 ms per step, 512 ms default, 15 s ceiling
`define WTC_WD_STEP_US 250
`define WTC_WD_DEFAULT_MS 512
`define WTC_WD_MAX_S 15
`define WTC_XTAL_DIV 8192
`define WTC_FS_DIV 2

// clock supervision window and token pulse width
`define WTC_CLK_FAULT_US 250
`define WTC_TOKEN_PULSE_NS 30
`define WTC_CLK_MHZ 20

`endif

// ==== wtc_partner.sv ====
/* far-side model: crystal, frame sync, upstream token neighbour, memory user.
 assumes the bench switches the clocks and requests token arrivals. */
`timescale 1ns/10ps
module wtc_partner (
   input wire logic clk,
   input wire logic nrst,
   input wire logic xtal_on,
   input wire logic fs_on,
   input wire logic tok_go,
   input wire logic mem_grant,
   output logic crystal_in,
   output logic frame_sync_8k,
   output logic token_in_pin,
   output logic mem_req,
   output logic mem_done
);
   logic [3:0] fs_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         crystal_in <= 1'b0;
         fs_q <= 4'h0;
         frame_sync_8k <= 1'b0;
         token_in_pin <= 1'b0;
         mem_req <= 1'b0;
         mem_done <= 1'b0;
      end else begin
         crystal_in <= xtal_on ? !crystal_in : crystal_in;
         fs_q <= (fs_q == 4'h9) ? 4'h0 : fs_q + 4'h1;
         // frame sync stands still when off, so supervision must notice
         if (fs_on && fs_q == 4'h9) frame_sync_8k <= !frame_sync_8k;
         token_in_pin <= tok_go;
         mem_req <= 1'b1;
         mem_done <= mem_grant && !mem_done;
      end
   end
endmodule

// ==== wtc_pkg.sv ====
/*
 Types shared by the watchdog and token control block.
 Assumes wtc_cfg.svh holds the numeric constants.
*/
package wtc_pkg;

   typedef enum logic [1:0] {
      WTC_TOK_IDLE = 2'b00,
      WTC_TOK_HOLD = 2'b01,
      WTC_TOK_ACCESS = 2'b10
   } wtc_tok_state_t;

endpackage

// ==== wtc_watchdog_token.sv ====
/*
 Watchdog with alarm pin, timestamp reuse of its counter, clock-fault
 interrupt, token chain control and the command/configuration registers.
 Assumes an Avalon-MM master with word addressing, a 20 MHz clock, pins
 from other domains on token_in_pin, frame_sync_8k and crystal_in, and
 memory-access logic on the same clock driving mem_req and mem_done.
*/
// Summary of operation
// - raise the clock-fault interrupt when the frame clock is missing
// - timestamp mode reuses the watchdog counter; watchdog then unavailable
// - watchdog counts down from the value software writes to the timer
// - full count-down without a clear activates the alarm pin
// - initial value 0 to 15 s in 0.25 ms steps
// - reset loads counter and timer with 512 ms
// - tick from frame sync / 2 or crystal / 8192; crystal after reset
// - hardware or software reset restores defaults, then pulses default load
// - ident register reads a fixed 16-bit circuit code untouched by reset
// - token-launch command sends a token pulse on the token output
// - writing bit 1 clears and restarts the watchdog
// - writing bit 2 resets configuration, watchdog, supervision and token logic like the reset pin
// - the three command bits clear themselves after each write
// - watchdog disable or timestamp mode keeps the alarm low; otherwise timeout drives high
// - priority hold captures a launched token and keeps it
// - without hold, access only with token, pass it after one access
// - token disable destroys the token, blocks access, output stays quiet
// - passing the token is one short pulse on the token output
// - detect missing clock within 250 us, repeat interrupt at 4 kHz
`timescale 1ns/10ps
`include "wtc_cfg.svh"

module wtc_watchdog_token #(
   parameter logic [15:0] CIRCUIT_CODE = 16'h5A31, // arbitrary value
   parameter int CLK_FAULT_CYCLES = (`WTC_CLK_FAULT_US * `WTC_CLK_MHZ),
   parameter int XTAL_DIV = `WTC_XTAL_DIV
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic crystal_in,
   input wire logic frame_sync_8k,
   input wire logic token_in_pin,
   output logic token_out_pin,
   input wire logic mem_req,
   input wire logic mem_done,
   output logic mem_grant,
   output logic watchdog_alarm_pin,
   output logic clock_fault_irq_pin,
   output logic [15:0] timestamp_word,
   output logic defaults_load
);

   localparam int WD_DEFAULT = (`WTC_WD_DEFAULT_MS * 1000) / `WTC_WD_STEP_US;
   localparam int WD_MAX = (`WTC_WD_MAX_S * 1000000) / `WTC_WD_STEP_US;
   localparam int TOKEN_PULSE_CYC_RAW = (`WTC_TOKEN_PULSE_NS * `WTC_CLK_MHZ + 999) / 1000;
   localparam int TOKEN_PULSE_CYC = (TOKEN_PULSE_CYC_RAW < 1) ? 1 : TOKEN_PULSE_CYC_RAW;

   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] idx);
      reg_hit = (addr == idx);
   endfunction

   // bus handshake: one wait state on every access
   logic ack_q;
   logic req;
   logic wr_take;
   logic srst_q;

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_take = avs_write & ack_q & avs_byteenable[0];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // command pulses live one cycle only
   logic launch_cmd;
   logic wd_clear_cmd;
   logic sw_reset_cmd;
   assign launch_cmd = wr_take & reg_hit(avs_address, `WTC_IDX_IDENT_CMD)
                       & avs_writedata[`WTC_CMD_TOKEN_LAUNCH];
   assign wd_clear_cmd = wr_take & reg_hit(avs_address, `WTC_IDX_IDENT_CMD)
                         & avs_writedata[`WTC_CMD_WD_CLEAR];
   assign sw_reset_cmd = wr_take & reg_hit(avs_address, `WTC_IDX_IDENT_CMD)
                         & avs_writedata[`WTC_CMD_SW_RESET];

   // software reset acts one cycle later on the configuration, watchdog, supervision and token registers below
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= sw_reset_cmd;
      end
   end

   // defaults are pushed to memories right after either reset
   logic load_pend_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         load_pend_q <= 1'b1;
         defaults_load <= 1'b0;
      end else begin
         defaults_load <= load_pend_q | srst_q;
         load_pend_q <= 1'b0;
      end
   end

   // configuration registers
   logic [15:0] cfg_q;
   logic [15:0] timer_q;
   logic timer_wr;
   assign timer_wr = wr_take & reg_hit(avs_address, `WTC_IDX_TIMER);
   logic [15:0] timer_new;
   // values beyond 15 s are clipped to the ceiling
   assign timer_new = (avs_writedata[15:0] > 16'(WD_MAX)) ? 16'(WD_MAX) : avs_writedata[15:0];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= `WTC_CFG_RESET;
      end else if (srst_q) begin
         cfg_q <= `WTC_CFG_RESET;
      end else if (wr_take && reg_hit(avs_address, `WTC_IDX_GEN_CFG)) begin
         cfg_q[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1]) begin
            cfg_q[15:8] <= avs_writedata[15:8];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_q <= 16'(WD_DEFAULT);
      end else if (srst_q) begin
         timer_q <= 16'(WD_DEFAULT);
      end else if (timer_wr && avs_byteenable[1]) begin
         timer_q <= timer_new;
      end
   end

   logic wd_disable;
   logic prio_hold;
   logic token_disable;
   logic ts_mode;
   assign wd_disable = cfg_q[`WTC_CFG_WD_DISABLE];
   assign prio_hold = cfg_q[`WTC_CFG_PRIO_HOLD];
   assign token_disable = cfg_q[`WTC_CFG_TOKEN_DISABLE];
   assign ts_mode = cfg_q[`WTC_CFG_TIMESTAMP];

   // pin synchronisers
   logic [1:0] xtal_s_q;
   logic [1:0] fs_s_q;
   logic [1:0] tok_s_q;
   logic xtal_d_q;
   logic fs_d_q;
   logic tok_d_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xtal_s_q <= 2'b00;
         fs_s_q <= 2'b00;
         tok_s_q <= 2'b00;
         xtal_d_q <= 1'b0;
         fs_d_q <= 1'b0;
         tok_d_q <= 1'b0;
      end else begin
         xtal_s_q <= {xtal_s_q[0], crystal_in};
         fs_s_q <= {fs_s_q[0], frame_sync_8k};
         tok_s_q <= {tok_s_q[0], token_in_pin};
         xtal_d_q <= xtal_s_q[1];
         fs_d_q <= fs_s_q[1];
         tok_d_q <= tok_s_q[1];
      end
   end

   logic xtal_rise;
   logic fs_rise;
   logic tok_rise;
   assign xtal_rise = xtal_s_q[1] & ~xtal_d_q;
   assign fs_rise = fs_s_q[1] & ~fs_d_q;
   assign tok_rise = tok_s_q[1] & ~tok_d_q;

   // watchdog tick prescalers; crystal edges above half clk rate are missed
   logic [12:0] xdiv_q;
   logic fdiv_q;
   logic wd_tick;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xdiv_q <= 13'h0000;
         fdiv_q <= 1'b0;
      end else if (srst_q) begin
         xdiv_q <= 13'h0000;
         fdiv_q <= 1'b0;
      end else begin
         if (xtal_rise) begin
            xdiv_q <= (xdiv_q == 13'(XTAL_DIV - 1)) ? 13'h0000 : xdiv_q + 13'h0001;
         end
         if (fs_rise) begin
            fdiv_q <= ~fdiv_q;
         end
      end
   end

   // frame sync halved or crystal divided; crystal source after reset
   assign wd_tick = cfg_q[`WTC_CFG_WD_SRC_FS] ? (fs_rise & fdiv_q)
                    : (xtal_rise & (xdiv_q == 13'(XTAL_DIV - 1)));

   // watchdog counter, also the timestamp base
   logic [15:0] wd_cnt_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wd_cnt_q <= 16'(WD_DEFAULT);
      end else if (srst_q) begin
         wd_cnt_q <= 16'(WD_DEFAULT);
      end else if (timer_wr && avs_byteenable[1]) begin
         wd_cnt_q <= timer_new;
      end else if (wd_clear_cmd) begin
         wd_cnt_q <= timer_q;
      end else if (wd_tick) begin
         if (wd_cnt_q != 16'h0000) begin
            wd_cnt_q <= wd_cnt_q - 16'h0001;
         end else if (ts_mode) begin
            wd_cnt_q <= timer_q;
         end
      end
   end
   assign timestamp_word = wd_cnt_q;

   // alarm latches until cleared; disabled or timestamping keeps it low
   logic alarm_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarm_q <= 1'b0;
      end else if (srst_q || wd_clear_cmd || wd_disable || ts_mode) begin
         alarm_q <= 1'b0;
      end else if (wd_cnt_q == 16'h0000) begin
         alarm_q <= 1'b1;
      end
   end
   assign watchdog_alarm_pin = alarm_q;

   // clock supervision on the frame sync distribution
   logic [15:0] miss_cnt_q;
   logic fault_q;
   logic fault_irq_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         miss_cnt_q <= 16'h0000;
         fault_q <= 1'b0;
         fault_irq_q <= 1'b0;
      end else if (srst_q || fs_rise) begin
         miss_cnt_q <= 16'h0000;
         fault_q <= 1'b0;
         fault_irq_q <= 1'b0;
      end else if (miss_cnt_q == 16'(CLK_FAULT_CYCLES - 1)) begin
         // restart the window so the pulse repeats every 250 us
         miss_cnt_q <= 16'h0000;
         fault_q <= 1'b1;
         fault_irq_q <= 1'b1;
      end else begin
         miss_cnt_q <= miss_cnt_q + 16'h0001;
         fault_irq_q <= 1'b0;
      end
   end
   assign clock_fault_irq_pin = fault_irq_q;

   // token chain
   wtc_pkg::wtc_tok_state_t tok_q;
   logic pass_q;
   logic [3:0] pulse_cnt_q;
   logic tok_arrive;
   assign tok_arrive = launch_cmd | tok_rise;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tok_q <= wtc_pkg::WTC_TOK_IDLE;
         pass_q <= 1'b0;
      end else if (srst_q) begin
         tok_q <= wtc_pkg::WTC_TOK_IDLE;
         pass_q <= 1'b0;
      end else begin
         pass_q <= 1'b0;
         case (tok_q)
            wtc_pkg::WTC_TOK_IDLE: begin
               if (tok_arrive && !token_disable) begin
                  if (prio_hold) begin
                     tok_q <= wtc_pkg::WTC_TOK_HOLD;
                  end else if (mem_req && tok_rise) begin
                     tok_q <= wtc_pkg::WTC_TOK_ACCESS;
                  end else begin
                     pass_q <= 1'b1;
                  end
               end
            end
            wtc_pkg::WTC_TOK_HOLD: begin
               if (token_disable) begin
                  tok_q <= wtc_pkg::WTC_TOK_IDLE;
               end else if (!prio_hold) begin
                  tok_q <= mem_req ? wtc_pkg::WTC_TOK_ACCESS : wtc_pkg::WTC_TOK_IDLE;
                  pass_q <= ~mem_req;
               end
            end
            wtc_pkg::WTC_TOK_ACCESS: begin
               if (token_disable) begin
                  tok_q <= wtc_pkg::WTC_TOK_IDLE;
               end else if (mem_done) begin
                  tok_q <= wtc_pkg::WTC_TOK_IDLE;
                  pass_q <= 1'b1;
               end
            end
            default: begin
               tok_q <= wtc_pkg::WTC_TOK_IDLE;
            end
         endcase
      end
   end

   // token output pulse, shortest whole-cycle width
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulse_cnt_q <= 4'h0;
         token_out_pin <= 1'b0;
      end else if (srst_q || token_disable) begin
         pulse_cnt_q <= 4'h0;
         token_out_pin <= 1'b0;
      end else if (pass_q) begin
         pulse_cnt_q <= 4'(TOKEN_PULSE_CYC - 1);
         token_out_pin <= 1'b1;
      end else if (pulse_cnt_q != 4'h0) begin
         pulse_cnt_q <= pulse_cnt_q - 4'h1;
      end else begin
         token_out_pin <= 1'b0;
      end
   end

   assign mem_grant = (tok_q != wtc_pkg::WTC_TOK_IDLE) & ~token_disable;

   // read path; unmapped words read zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         avs_readdata <= 32'h00000000;
         if (reg_hit(avs_address, `WTC_IDX_IDENT_CMD)) begin
            avs_readdata[15:0] <= CIRCUIT_CODE;
         end else if (reg_hit(avs_address, `WTC_IDX_GEN_CFG)) begin
            avs_readdata[15:0] <= cfg_q;
         end else if (reg_hit(avs_address, `WTC_IDX_TIMER)) begin
            avs_readdata[15:0] <= timer_q;
         end else if (reg_hit(avs_address, `WTC_IDX_STATUS)) begin
            avs_readdata[31:16] <= wd_cnt_q;
            avs_readdata[`WTC_ST_ALARM] <= alarm_q;
            avs_readdata[`WTC_ST_CLK_FAULT] <= fault_q;
            avs_readdata[`WTC_ST_TOKEN_HELD] <= mem_grant;
         end
      end
   end

endmodule

// ==== wtc_watchdog_token_checker.sv ====
/* port assertions for the watchdog and token block.
 assumes one clock domain; bound at the foot of this file. */
`timescale 1ns/10ps
`include "wtc_cfg.svh"
module wtc_watchdog_token_checker #(
   parameter logic [15:0] CIRCUIT_CODE = 16'h5A31, // arbitrary value
   parameter int CLK_FAULT_CYCLES = (`WTC_CLK_FAULT_US * `WTC_CLK_MHZ)
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic frame_sync_8k,
   input wire logic token_out_pin,
   input wire logic mem_grant,
   input wire logic watchdog_alarm_pin,
   input wire logic clock_fault_irq_pin,
   input wire logic defaults_load
);
   logic wr_ok, cmd_ok;
   logic [15:0] cfg_q;
   logic [15:0] gap_q, idle_q;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign cmd_ok = wr_ok && avs_byteenable[0] && avs_address == `WTC_IDX_IDENT_CMD;
   // shadow of the configuration, as the ports show it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= 16'h0000;
         gap_q <= 16'h0000;
         idle_q <= 16'h0000;
      end else begin
         if (wr_ok && avs_byteenable[0] && avs_address == `WTC_IDX_GEN_CFG) cfg_q <= avs_writedata[15:0];
         if (cmd_ok && avs_writedata[2]) cfg_q <= 16'h0000;
         gap_q <= (clock_fault_irq_pin || idle_q == 16'h0000) ? 16'h0000 : gap_q + 16'h0001;
         // supervision counts rising edges only
         idle_q <= $rose(frame_sync_8k) ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hFFFF};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ident_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
      |-> avs_readdata[15:0] == CIRCUIT_CODE) else $error("ident code wrong");
   alarm_hold_a: assert property (watchdog_alarm_pin && !wr_ok && !$past(wr_ok) |=> watchdog_alarm_pin)
      else $error("alarm dropped");
   alarm_mask_a: assert property (cfg_q[0] && $past(cfg_q[0]) |-> !watchdog_alarm_pin)
      else $error("alarm while disabled");
   wd_clear_a: assert property (cmd_ok && avs_writedata[1] |=> !watchdog_alarm_pin)
      else $error("clear ignored");
   tok_pulse_a: assert property (token_out_pin |=> !token_out_pin) else $error("token pulse wide");
   tok_kill_a: assert property (cfg_q[2] && $past(cfg_q[2]) |-> !mem_grant && !token_out_pin)
      else $error("token alive while disabled");
   token_launch_a: assert property (cmd_ok && avs_writedata[2:0] == 3'h1 && cfg_q[2:1] == 2'h0
      |-> ##[1:3] token_out_pin) else $error("no token launched");
   sw_reset_a: assert property (cmd_ok && avs_writedata[2] |-> ##[1:3] defaults_load)
      else $error("no default load");
   fault_gap_a: assert property (gap_q <= CLK_FAULT_CYCLES + 6) else $error("fault irq late");
   fault_cause_a: assert property (clock_fault_irq_pin |-> $past(idle_q, 4) >= CLK_FAULT_CYCLES - 16)
      else $error("fault irq with clock present");
endmodule
bind wtc_watchdog_token wtc_watchdog_token_checker #(.CIRCUIT_CODE(CIRCUIT_CODE),
   .CLK_FAULT_CYCLES(CLK_FAULT_CYCLES)) wtc_watchdog_token_checker_i (.clk(clk), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .frame_sync_8k(frame_sync_8k), .token_out_pin(token_out_pin), .mem_grant(mem_grant),
   .watchdog_alarm_pin(watchdog_alarm_pin), .clock_fault_irq_pin(clock_fault_irq_pin),
   .defaults_load(defaults_load));

// ==== wtc_watchdog_token_tb.sv ====
/* self-checking bench for the watchdog and token block.
 assumes the partner model and short counts: fault window 50, crystal divide 4. */
`timescale 1ns/10ps
`include "wtc_cfg.svh"
module wtc_watchdog_token_tb;
   localparam logic [15:0] CODE = 16'h3C96; // arbitrary value
   localparam logic [31:0] TDEF = `WTC_WD_DEFAULT_MS * 1000 / `WTC_WD_STEP_US;
   localparam logic [31:0] TMAX = `WTC_WD_MAX_S * 1000000 / `WTC_WD_STEP_US;
   logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic xtal_on = 1'b0, fs_on = 1'b1, tok_go = 1'b0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, crystal_in, frame_sync_8k, token_in_pin, token_out_pin;
   logic mem_req, mem_done, mem_grant, watchdog_alarm_pin, clock_fault_irq_pin, defaults_load;
   logic [15:0] timestamp_word;
   int bad_count = 0, cmp_count = 0, cyc = 0, n, i;
   wtc_watchdog_token #(.CIRCUIT_CODE(CODE), .CLK_FAULT_CYCLES(50), .XTAL_DIV(4)) wtc_watchdog_token_i (
      .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .crystal_in(crystal_in), .frame_sync_8k(frame_sync_8k),
      .token_in_pin(token_in_pin), .token_out_pin(token_out_pin), .mem_req(mem_req), .mem_done(mem_done),
      .mem_grant(mem_grant), .watchdog_alarm_pin(watchdog_alarm_pin),
      .clock_fault_irq_pin(clock_fault_irq_pin), .timestamp_word(timestamp_word),
      .defaults_load(defaults_load));
   wtc_partner wtc_partner_i (.clk(clk), .nrst(nrst), .xtal_on(xtal_on), .fs_on(fs_on), .tok_go(tok_go),
      .mem_grant(mem_grant), .crystal_in(crystal_in), .frame_sync_8k(frame_sync_8k),
      .token_in_pin(token_in_pin), .mem_req(mem_req), .mem_done(mem_done));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_sim;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 16'h0000);
      chk(what, exp, q);
   endtask
   task automatic watch(ref logic s, input int lim);
      n = 0;
      repeat (lim) begin
         @(posedge clk);
         if (s === 1'b1) n++;
      end
   endtask
   task automatic pulse_tok;
      @(posedge clk);
      tok_go <= 1'b1;
      @(posedge clk);
      tok_go <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd(`WTC_IDX_IDENT_CMD, {16'h0000, CODE}, "ident");
      rd(`WTC_IDX_GEN_CFG, 32'h0, "cfg");
      rd(`WTC_IDX_TIMER, TDEF, "timer");
      rd(4'hF, 32'h0, "unmapped");
      avs_byteenable <= 4'h0;
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0004);
      avs_byteenable <= 4'hF;
      rd(`WTC_IDX_GEN_CFG, 32'h0, "no lanes");
      bus(1'b1, `WTC_IDX_TIMER, 16'hFFFF);
      rd(`WTC_IDX_TIMER, TMAX, "timer clip");
      xtal_on <= 1'b1;
      bus(1'b1, `WTC_IDX_TIMER, 16'h0003);
      watch(watchdog_alarm_pin, 10);
      chk("early alarm", 0, n);
      watch(watchdog_alarm_pin, 200);
      chk("alarm", 1, n > 0);
      rd(`WTC_IDX_STATUS, 32'h1, "status");
      chk("status alarm", 1, q[0]);
      watch(watchdog_alarm_pin, 30);
      chk("alarm held", 30, n);
      bus(1'b1, `WTC_IDX_IDENT_CMD, 16'h0002);
      watch(watchdog_alarm_pin, 10);
      chk("cleared", 0, n);
      rd(`WTC_IDX_IDENT_CMD, {16'h0000, CODE}, "ident after cmd");
      for (i = 0; i < 2; i++) begin
         bus(1'b1, `WTC_IDX_GEN_CFG, i ? 16'h0010 : 16'h0001);
         bus(1'b1, `WTC_IDX_IDENT_CMD, 16'h0002);
         watch(watchdog_alarm_pin, 200);
         chk("masked alarm", 0, n);
         chk("stamp range", 1, timestamp_word <= 16'h0003);
      end
      xtal_on <= 1'b0;
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0008);
      bus(1'b1, `WTC_IDX_IDENT_CMD, 16'h0002);
      watch(watchdog_alarm_pin, 400);
      chk("fs alarm", 1, n > 0);
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0001);
      fs_on <= 1'b0;
      watch(clock_fault_irq_pin, 220);
      chk("fault pulses", 1, n >= 3 && n <= 5);
      fs_on <= 1'b1;
      watch(clock_fault_irq_pin, 40);
      watch(clock_fault_irq_pin, 200);
      chk("no fault", 0, n);
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0000);
      bus(1'b1, `WTC_IDX_IDENT_CMD, 16'h0001);
      watch(token_out_pin, 6);
      chk("launch", 1, n);
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0004);
      bus(1'b1, `WTC_IDX_IDENT_CMD, 16'h0001);
      pulse_tok;
      watch(token_out_pin, 20);
      chk("killed", 0, n);
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0002);
      chk("no grant", 0, mem_grant);
      pulse_tok;
      watch(mem_grant, 10);
      watch(mem_grant, 20);
      chk("held", 20, n);
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0000);
      watch(token_out_pin, 20);
      chk("passed on", 1, n);
      pulse_tok;
      watch(token_out_pin, 20);
      chk("one access", 1, n);
      bus(1'b1, `WTC_IDX_GEN_CFG, 16'h0005);
      bus(1'b1, `WTC_IDX_TIMER, 16'h0007);
      bus(1'b1, `WTC_IDX_IDENT_CMD, 16'h0004);
      watch(defaults_load, 5);
      chk("default load", 1, n);
      rd(`WTC_IDX_GEN_CFG, 32'h0, "cfg after reset");
      rd(`WTC_IDX_TIMER, TDEF, "timer after reset");
      rd(`WTC_IDX_IDENT_CMD, {16'h0000, CODE}, "ident kept");
      end_sim;
   end
endmodule
